// file: verilog/pda_pkg.sv
// Shared constants for the port direction and access block.
package pda_pkg;

  // Access widths presented by the CPU core.
  typedef enum logic [1:0] {
    W_BIT  = 2'b00,
    W_NIB  = 2'b01,
    W_BYTE = 2'b10
  } pda_width_t;

  // Operations presented by the CPU core.
  typedef enum logic [2:0] {
    OP_RD   = 3'b000,
    OP_WR   = 3'b001,
    OP_XCH  = 3'b010,
    OP_INC  = 3'b011,
    OP_SET  = 3'b100,
    OP_CLR  = 3'b101,
    OP_TCLR = 3'b110
  } pda_op_t;

  // Data memory addresses of the ports and the direction registers.
  localparam logic [7:0]  PORT_PAGE    = 8'hff;
  localparam logic [3:0]  PORT_LAST    = 4'h8;
  localparam logic [3:0]  PORT_FIRST_IO = 4'h2;
  localparam logic [11:0] PAIR_ADDR    = 12'hff4;
  localparam logic [11:0] DIR_A_ADDR   = 12'hfe8;
  localparam logic [11:0] DIR_B_ADDR   = 12'hfec;
  localparam logic [11:0] DIR_C_ADDR   = 12'hfee;

  // Bank that opens nibble and byte access when banking is enabled.
  localparam logic [3:0]  PORT_BANK    = 4'hf;

  // Field positions inside the direction registers.
  localparam int DIRA_P3_LSB = 0;
  localparam int DIRA_P6_LSB = 4;
  localparam int DIRB_P2     = 2;
  localparam int DIRB_P4     = 4;
  localparam int DIRB_P5     = 5;
  localparam int DIRB_P7     = 7;
  localparam int DIRC_P8     = 0;

  // Reset values of the direction registers and output latches.
  localparam logic [7:0]  DIR_RESET    = 8'h00;
  localparam logic [27:0] LATCH_RESET  = 28'h0000000;

endpackage

// file: verilog/pda_latch_bank.sv
`timescale 1ns/100ps
// Output latches of ports 2 to 8, four bits per port, bit-writable.
module pda_latch_bank #(
  parameter int WIDTH = 28
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic [WIDTH-1:0] we,
  input  wire logic [WIDTH-1:0] wd,
  output logic      [WIDTH-1:0] q
);

  // Each bit updates only when its own enable is set, so a bit write
  // leaves the neighbouring latch bits untouched.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      q <= pda_pkg::LATCH_RESET[WIDTH-1:0];
    end else begin
      q <= (q & ~we) | (wd & we);
    end
  end

endmodule

// file: verilog/pda_top.sv
`timescale 1ns/100ps
module pda_top (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        accValid,
  input  wire logic [1:0]  accWidth,
  input  wire logic [2:0]  accOp,
  input  wire logic [11:0] accAddr,
  input  wire logic [1:0]  accBit,
  input  wire logic        bitIndirect,
  input  wire logic [3:0]  lowIndex,
  input  wire logic [7:0]  wrData,
  input  wire logic        bank_enable_flag,
  input  wire logic [3:0]  bank_select_field,
  input  wire logic [35:0] pinIn,
  output logic      [7:0]  rdData,
  output logic             accAck,
  output logic             accSkip,
  output logic      [27:0] pinOut,
  output logic      [27:0] pinOe
);

  logic        rstMeta;          // First reset synchroniser stage.
  logic        rstN;             // Synchronised active-low reset.
  logic [7:0]  port_dir_group_a; // Per-pin direction of ports 3 and 6.
  logic [7:0]  port_dir_group_b; // Per-port direction of 2, 4, 5, 7.
  logic [7:0]  port_dir_group_c; // Direction of port 8.
  logic [27:0] latchQ;           // Output latches of ports 2 to 8.
  logic [27:0] latchWe;          // Per-bit latch write enables.
  logic [27:0] latchWd;          // Per-bit latch write data.

  // Reset is released through two flops so that every flop leaves reset
  // on the same edge; assertion is still immediate.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // Address decode. Indirect bit mode swaps in the index register.
  wire        isBit   = accWidth == pda_pkg::W_BIT;
  wire        isNib   = accWidth == pda_pkg::W_NIB;
  wire        isByte  = accWidth == pda_pkg::W_BYTE;
  wire        useInd  = isBit && bitIndirect;
  wire [11:0] effAddr = useInd ? {accAddr[11:2], lowIndex[3:2]}
                               : accAddr;
  wire [1:0]  effBit  = useInd ? lowIndex[1:0] : accBit;
  wire [3:0]  portNo  = effAddr[3:0];
  wire        isPort  = effAddr[11:4] == pda_pkg::PORT_PAGE &&
                        portNo <= pda_pkg::PORT_LAST;
  wire        isIo    = portNo >= pda_pkg::PORT_FIRST_IO;
  wire        bankOk  = !bank_enable_flag ||
                        bank_select_field == pda_pkg::PORT_BANK;
  wire        bitHit  = accValid && isBit && isPort;
  wire        nibHit  = accValid && isNib && bankOk && isPort;
  wire        byteHit = accValid && isByte && bankOk &&
                        effAddr == pda_pkg::PAIR_ADDR;
  // Direction registers answer to byte accesses only; narrower
  // accesses to their addresses are ignored.
  wire        dirHit  = accValid && isByte && bankOk;
  wire        hitA    = dirHit && effAddr == pda_pkg::DIR_A_ADDR;
  wire        hitB    = dirHit && effAddr == pda_pkg::DIR_B_ADDR;
  wire        hitC    = dirHit && effAddr == pda_pkg::DIR_C_ADDR;
  wire        dirWr   = accOp == pda_pkg::OP_WR;
  wire        anyHit  = bitHit || nibHit || byteHit || hitA || hitB || hitC;

  // Per-pin direction, four bits per port, port n at bits 4n+3..4n.
  wire [35:0] dirBits = {
    2'b00, {2{port_dir_group_c[pda_pkg::DIRC_P8]}},
    {4{port_dir_group_b[pda_pkg::DIRB_P7]}},
    port_dir_group_a[pda_pkg::DIRA_P6_LSB +: 4],
    {4{port_dir_group_b[pda_pkg::DIRB_P5]}},
    {4{port_dir_group_b[pda_pkg::DIRB_P4]}},
    port_dir_group_a[pda_pkg::DIRA_P3_LSB +: 4],
    {4{port_dir_group_b[pda_pkg::DIRB_P2]}},
    8'h00};

  // Read view: latch in output mode, pin level in input mode.
  wire [35:0] latchFull = {latchQ, 8'h00};
  wire [35:0] curVal    = (latchFull & dirBits) |
                          (pinIn & ~dirBits);
  wire [5:0]  nibIdx    = {portNo[3:0], 2'b00};
  wire [5:0]  bitPos    = nibIdx | {4'h0, effBit};
  wire [3:0]  curNib    = curVal[nibIdx +: 4];
  wire        curBitV   = curVal[bitPos];
  wire [7:0]  pairVal   = curVal[23:16];
  wire [3:0]  incNib    = curNib + 4'h1;

  // Latch write enables and data across all nine ports, trimmed to the
  // seven ports that own latches. Ports 0 and 1 never take a write.
  wire        nibWr   = nibHit && isIo && (accOp == pda_pkg::OP_WR ||
                        accOp == pda_pkg::OP_XCH ||
                        accOp == pda_pkg::OP_INC);
  wire        byteWr  = byteHit && (accOp == pda_pkg::OP_WR ||
                        accOp == pda_pkg::OP_XCH);
  wire        bitWr   = bitHit && isIo && accOp != pda_pkg::OP_RD &&
                        accOp != pda_pkg::OP_XCH &&
                        accOp != pda_pkg::OP_INC;
  wire        bitVal  = accOp == pda_pkg::OP_SET ? 1'b1 :
                        accOp == pda_pkg::OP_WR  ? wrData[0] : 1'b0;
  wire [3:0]  nibData = accOp == pda_pkg::OP_INC ? incNib : wrData[3:0];
  wire [35:0] nibMask = 36'h00000000f << nibIdx;
  wire [35:0] bitMask = 36'h000000001 << bitPos;
  wire [35:0] we36    = (nibWr  ? nibMask : 36'h000000000) |
                        (bitWr  ? bitMask : 36'h000000000) |
                        (byteWr ? 36'h000ff0000 : 36'h000000000);
  wire [35:0] wd36    = isBit  ? {36{bitVal}} :
                        isByte ? {12'h000, wrData, 16'h0000} :
                                 {9{nibData}};
  assign latchWe = we36[35:8];
  assign latchWd = wd36[35:8];

  // Answer data for the taken access.
  wire [7:0]  rdNext = isBit  ? {7'h00, curBitV} :
                       hitA   ? port_dir_group_a :
                       hitB   ? port_dir_group_b :
                       hitC   ? port_dir_group_c :
                       isByte ? pairVal : {4'h0, curNib};
  wire        skipNext = nibHit && accOp == pda_pkg::OP_INC &&
                         curNib == 4'hf;

  // Output latches live in their own bank.
  pda_latch_bank #(
    .WIDTH (28)
  ) uLatch (
    .clk  (mclk),
    .rstN (rstN),
    .we   (latchWe),
    .wd   (latchWd),
    .q    (latchQ)
  );

  // Direction registers; reset leaves every port in input mode.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      port_dir_group_a <= pda_pkg::DIR_RESET;
      port_dir_group_b <= pda_pkg::DIR_RESET;
      port_dir_group_c <= pda_pkg::DIR_RESET;
    end else begin
      if (hitA && dirWr) begin
        port_dir_group_a <= wrData;
      end
      if (hitB && dirWr) begin
        port_dir_group_b <= wrData;
      end
      if (hitC && dirWr) begin
        port_dir_group_c <= wrData;
      end
    end
  end

  // Pin drivers are registered, so a direction or latch change shows on
  // the pins one cycle after the register that caused it.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pinOut <= pda_pkg::LATCH_RESET;
      pinOe  <= 28'h0000000;
    end else begin
      pinOut <= latchQ;
      pinOe  <= dirBits[35:8];
    end
  end

  // Answer registers: acknowledge, read data and increment skip.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rdData  <= 8'h00;
      accAck  <= 1'b0;
      accSkip <= 1'b0;
    end else begin
      accAck  <= anyHit;
      accSkip <= skipNext;
      if (anyHit) begin
        rdData <= rdNext;
      end
    end
  end

  // Checks of the documented behaviour.
  a_reset_clear: assert property (@(posedge mclk)
    !rstN |-> (pinOe == 28'h0000000 && pinOut == 28'h0000000 &&
               latchQ == 28'h0000000))
    else $error("Pins or latches not cleared in reset.");

  a_dir_reset: assert property (@(posedge mclk)
    !rstN |-> (port_dir_group_a == 8'h00 && port_dir_group_b == 8'h00
               && port_dir_group_c == 8'h00))
    else $error("Direction registers not cleared in reset.");

  a_dir_byte_write: assert property (@(posedge mclk) disable iff (!rstN)
    hitA && dirWr |=> port_dir_group_a == $past(wrData))
    else $error("Direction byte write not taken.");

  a_dir_nib_ignored: assert property (@(posedge mclk) disable iff (!rstN)
    accValid && isNib && effAddr == pda_pkg::DIR_A_ADDR
    |=> $stable(port_dir_group_a))
    else $error("Nibble access changed a direction register.");

  a_oe_port3: assert property (@(posedge mclk) disable iff (!rstN)
    ##1 pinOe[7:4] == $past(port_dir_group_a[3:0]))
    else $error("Port 3 enables do not follow their bits.");

  a_oe_port8: assert property (@(posedge mclk) disable iff (!rstN)
    ##1 pinOe[27:24] == {2'b00, {2{$past(port_dir_group_c[0])}}})
    else $error("Port 8 enables do not follow their bit.");

  a_oe_port5: assert property (@(posedge mclk) disable iff (!rstN)
    ##1 pinOe[15:12] == {4{$past(port_dir_group_b[5])}})
    else $error("Port 5 enables do not follow their bit.");

  a_pin_latch: assert property (@(posedge mclk) disable iff (!rstN)
    ##1 pinOut == $past(latchQ))
    else $error("Pins do not show the output latches.");

  a_bit_any_bank: assert property (@(posedge mclk) disable iff (!rstN)
    accValid && isBit && isPort |=> accAck)
    else $error("Bit access to a port was refused.");

  a_nib_bank_gate: assert property (@(posedge mclk) disable iff (!rstN)
    accValid && isNib && !bankOk |=> !accAck)
    else $error("Nibble access taken outside bank 15.");

  a_pair_write: assert property (@(posedge mclk) disable iff (!rstN)
    byteHit && accOp == pda_pkg::OP_WR |=> latchQ[15:8] == $past(wrData))
    else $error("Byte write did not reach ports 4 and 5.");

  a_ind_bit_set: assert property (@(posedge mclk) disable iff (!rstN)
    bitHit && useInd && isIo && accOp == pda_pkg::OP_SET
    |=> latchFull[$past(bitPos)])
    else $error("Indirect bit set missed its pin.");

  a_inc_skip: assert property (@(posedge mclk) disable iff (!rstN)
    nibHit && accOp == pda_pkg::OP_INC && curNib == 4'hf |=> accSkip)
    else $error("Increment wrap did not skip.");

  a_read_mode: assert property (@(posedge mclk) disable iff (!rstN)
    nibHit && accOp == pda_pkg::OP_RD && portNo == 4'h3
    |=> rdData[3:0] == $past((latchQ[7:4] & dirBits[15:12]) |
                             (pinIn[15:12] & ~dirBits[15:12])))
    else $error("Port read returned the wrong source.");

endmodule

// file: verif/pda_pin_model.sv
`timescale 1ns/100ps
// Pins seen from the board. A driven pin reads back its own level unless
// the bench shorts it, so the input-versus-latch choice becomes visible.
module pda_pin_model (
  input  wire logic [27:0] pinOut,
  input  wire logic [27:0] pinOe,
  input  wire logic [35:0] extLevel,
  input  wire logic        pinShort,
  output logic      [35:0] pinIn
);
  // Ports 0 and 1 are input only, so the board level always reaches them.
  assign pinIn[7:0] = extLevel[7:0];
  // A short is a board fault that overrides the output buffer.
  assign pinIn[35:8] = pinShort ? extLevel[35:8] :
                       (pinOe & pinOut) | (~pinOe & extLevel[35:8]);
endmodule

// file: verif/port_direction_and_access_tb_top.sv
`timescale 1ns/100ps
// Drives CPU accesses, notes each answer in a queue and checks the pins.
module port_direction_and_access_tb_top;
  // One expected answer: data, the data bits that matter, the skip flag.
  typedef struct {
    logic [7:0] d;
    logic [7:0] m;
    logic       s;
  } pda_note_t;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        accValid = 1'b0;
  logic [1:0]  accWidth = 2'h0;
  logic [2:0]  accOp = 3'h0;
  logic [11:0] accAddr = 12'h000;
  logic [1:0]  accBit = 2'h0;
  logic        bitIndirect = 1'b0;
  logic [3:0]  lowIndex = 4'h0;
  logic [7:0]  wrData = 8'h00;
  logic        bankFlag = 1'b0;
  logic [3:0]  bankField = 4'h0;
  logic [35:0] ext = 36'h0;
  logic        shortPin = 1'b0;
  logic [35:0] pinIn;
  logic [7:0]  rdData;
  logic        accAck;
  logic        accSkip;
  logic [27:0] pinOut;
  logic [27:0] pinOe;
  logic [3:0]  lat [0:8] = '{default: 4'h0};
  logic [7:0]  dA = 8'h00;
  logic [7:0]  dB = 8'h00;
  logic [7:0]  dC = 8'h00;
  logic [31:0] rnd = 32'h7f1fa08e;
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          p;
  pda_note_t   q[$];
  pda_note_t   e;

  always #2 mclk = ~mclk;

  pda_top u_dut (.mclk(mclk), .nrst(nrst), .accValid(accValid),
    .accWidth(accWidth), .accOp(accOp), .accAddr(accAddr), .accBit(accBit),
    .bitIndirect(bitIndirect), .lowIndex(lowIndex), .wrData(wrData),
    .bank_enable_flag(bankFlag), .bank_select_field(bankField),
    .pinIn(pinIn), .rdData(rdData), .accAck(accAck), .accSkip(accSkip),
    .pinOut(pinOut), .pinOe(pinOe));
  pda_pin_model u_pins (.pinOut(pinOut), .pinOe(pinOe), .extLevel(ext),
    .pinShort(shortPin), .pinIn(pinIn));

  // Expected enables, built field by field from the direction registers.
  function automatic logic [27:0] oeVec();
    return {2'b00, {2{dC[0]}}, {4{dB[7]}}, dA[7:4], {4{dB[5]}},
            {4{dB[4]}}, dA[3:0], {4{dB[2]}}};
  endfunction
  // What a read returns: latch where driven, pin level elsewhere.
  function automatic logic [3:0] view(input int pn);
    logic [27:0] t;
    t = (pn < 2) ? 28'h0 : oeVec() >> (4 * (pn - 2));
    return (lat[pn] & t[3:0]) | (ext[4*pn +: 4] & ~t[3:0]);
  endfunction
  // Next value of the bench's random source.
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One access, launched just after an edge and held for one cycle.
  task automatic acc(input logic [1:0] w, input logic [2:0] op,
                     input logic [11:0] a, input logic [7:0] wd, input bit hit,
                     input logic [7:0] d, input logic [7:0] m, input logic s);
    accWidth = w;
    accOp = op;
    accAddr = a;
    wrData = wd;
    accValid = 1'b1;
    if (hit) q.push_back('{d, m, s});
    @(posedge mclk);
    #1;
  endtask
  task automatic nib(input logic [2:0] op, input int pn, input logic [3:0] v,
                     input bit hit, input logic [7:0] m, input logic s);
    acc(pda_pkg::W_NIB, op, {pda_pkg::PORT_PAGE, pn[3:0]}, {4'h0, v}, hit,
        {4'h0, view(pn)}, m, s);
    if (op == pda_pkg::OP_WR && pn > 1) lat[pn] = v;
  endtask
  task automatic bitAcc(input logic [2:0] op, input int pn, input logic d);
    acc(pda_pkg::W_BIT, op, {pda_pkg::PORT_PAGE, pn[3:0]}, 8'h00, 1'b1,
        {7'h0, d}, {7'h0, op != pda_pkg::OP_SET}, 1'b0);
  endtask
  task automatic wrDirs();
    acc(pda_pkg::W_BYTE, pda_pkg::OP_WR, pda_pkg::DIR_A_ADDR, dA, 1, 0, 0, 0);
    acc(pda_pkg::W_BYTE, pda_pkg::OP_WR, pda_pkg::DIR_B_ADDR, dB, 1, 0, 0, 0);
    acc(pda_pkg::W_BYTE, pda_pkg::OP_WR, pda_pkg::DIR_C_ADDR, dC, 1, 0, 0, 0);
    acc(pda_pkg::W_BYTE, pda_pkg::OP_RD, pda_pkg::DIR_B_ADDR, 0, 1, dB, 8'hff,
        0);
  endtask
  // Registered pins lag the access, so let a few edges pass first.
  task automatic pinChk();
    accValid = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk("pinOe", oeVec(), pinOe);
    chk("pinOut", {lat[8], lat[7], lat[6], lat[5], lat[4], lat[3], lat[2]},
        pinOut);
  endtask
  task automatic complete_run();
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Every answer pops the oldest note; an answer with no note is a fault.
  always @(negedge mclk) begin
    if (accAck === 1'b1) begin
      if (q.size() == 0) chk("ack", 0, 1);
      else begin
        e = q.pop_front();
        chk("rdData", e.d & e.m, rdData & e.m);
        chk("accSkip", e.s, accSkip);
      end
    end
  end
  // Hang guard, far above the roughly 165 cycles the run needs.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    repeat (5) @(posedge mclk);
    #1 nrst = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    pinChk();
    wrDirs();
    // Latches first and directions after, so no pin drives stale data.
    for (int it = 0; it < 3; it++) begin
      bankFlag = it[0];
      bankField = 4'hf;
      for (int k = 2; k <= 8; k++) begin
        rnd = lfsr(rnd);
        nib(pda_pkg::OP_WR, k, (k == 8) ? {2'b00, rnd[1:0]} : rnd[3:0], 1,
            0, 0);
      end
      {dC, dB, dA} = rnd[23:0];
      wrDirs();
      pinChk();
    end
    shortPin = 1'b1;
    ext = {rnd, rnd[7:4]};
    nib(pda_pkg::OP_WR, 0, 4'ha, 1, 0, 0);
    for (int k = 0; k < 8; k++) nib(pda_pkg::OP_RD, k, 0, 1, 8'h0f, 0);
    acc(pda_pkg::W_BYTE, pda_pkg::OP_RD, pda_pkg::PAIR_ADDR, 0, 1,
        {view(5), view(4)}, 8'hff, 0);
    nib(pda_pkg::OP_XCH, 4, rnd[11:8], 1, 8'h0f, 0);
    lat[4] = rnd[11:8];
    shortPin = 1'b0;
    {dC, dB, dA} = 24'hffffff;
    wrDirs();
    nib(pda_pkg::OP_WR, 5, 4'hf, 1, 0, 0);
    nib(pda_pkg::OP_INC, 5, 0, 1, 0, 1);
    lat[5] = 4'h0;
    nib(pda_pkg::OP_WR, 7, {1'b0, rnd[2:0]}, 1, 0, 0);
    nib(pda_pkg::OP_INC, 7, 0, 1, 0, 0);
    lat[7] = lat[7] + 4'h1;
    nib(pda_pkg::OP_RD, 5, 0, 1, 8'h0f, 0);
    nib(pda_pkg::OP_RD, 7, 0, 1, 8'h0f, 0);
    // Pair write then exchange: the old pair value comes back from latches.
    acc(pda_pkg::W_BYTE, pda_pkg::OP_WR, pda_pkg::PAIR_ADDR, rnd[15:8], 1,
        0, 0, 0);
    acc(pda_pkg::W_BYTE, pda_pkg::OP_XCH, pda_pkg::PAIR_ADDR, rnd[23:16], 1,
        rnd[15:8], 8'hff, 0);
    {lat[5], lat[4]} = rnd[23:16];
    // Bit modes must work with banking on and a foreign bank selected.
    bankFlag = 1'b1;
    bankField = 4'h0;
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      p = 2 + rnd[4:2] % 7;
      accBit = (p == 8) ? {1'b0, rnd[0]} : rnd[1:0];
      bitAcc(pda_pkg::OP_SET, p, 0);
      bitAcc(pda_pkg::OP_TCLR, p, 1);
      bitAcc(pda_pkg::OP_RD, p, 0);
      // Plain bit write of a one, then a clear, each read back.
      acc(pda_pkg::W_BIT, pda_pkg::OP_WR, {pda_pkg::PORT_PAGE, p[3:0]}, 8'h01,
          1, 0, 0, 0);
      bitAcc(pda_pkg::OP_RD, p, 1);
      acc(pda_pkg::W_BIT, pda_pkg::OP_CLR, {pda_pkg::PORT_PAGE, p[3:0]}, 8'h00,
          1, 0, 0, 0);
      bitAcc(pda_pkg::OP_RD, p, 0);
      lat[p][accBit] = 1'b0;
      bitIndirect = 1'b1;
      lowIndex = rnd[8:5];
      acc(pda_pkg::W_BIT, pda_pkg::OP_SET, pda_pkg::PAIR_ADDR, 0, 1, 0, 0, 0);
      lat[4 + lowIndex[3:2]][lowIndex[1:0]] = 1'b1;
      bitIndirect = 1'b0;
      accBit = lowIndex[1:0];
      bitAcc(pda_pkg::OP_RD, 4 + lowIndex[3:2], 1);
    end
    pinChk();
    // Nibble and byte accesses outside bank 15 must be ignored.
    for (int f = 0; f < 15; f++) begin
      bankField = f[3:0];
      nib(pda_pkg::OP_RD, 3, 0, 0, 0, 0);
      acc(pda_pkg::W_BYTE, pda_pkg::OP_RD, pda_pkg::PAIR_ADDR, 0, 0, 0, 0, 0);
    end
    bankField = 4'hf;
    nib(pda_pkg::OP_RD, 3, 0, 1, 8'h0f, 0);
    acc(pda_pkg::W_NIB, pda_pkg::OP_RD, pda_pkg::DIR_A_ADDR, 0, 0, 0, 0, 0);
    acc(pda_pkg::W_BYTE, pda_pkg::OP_RD, 12'hff3, 0, 0, 0, 0, 0);
    acc(pda_pkg::W_NIB, pda_pkg::OP_RD, 12'h100, 0, 0, 0, 0, 0);
    pinChk();
    // A second reset in mid-run must clear latches and directions again.
    nrst = 1'b0;
    repeat (2) @(posedge mclk);
    #1 nrst = 1'b1;
    lat = '{default: 4'h0};
    {dC, dB, dA} = 24'h000000;
    repeat (3) @(posedge mclk);
    #1;
    acc(pda_pkg::W_BYTE, pda_pkg::OP_RD, pda_pkg::DIR_A_ADDR, 0, 1, 8'h00,
        8'hff, 0);
    pinChk();
    chk("queue", 0, q.size());
    complete_run();
  end
endmodule
